// [core/acs_regs.svh]
// Constants of the converter sequencer: offsets, fields, resets, timing.
// Assumes a 40 MHz system clock and the plain register port of acs_top.
//
// What this block does
// R1 - Continuous mode: first conversion starts 28.5 (normal) or 105 (turbo) cycles after start.
// R2 - Continuous mode: ready falls once per conversion length, both modes.
// R3 - Single-shot: ready falls the single-shot count after the start latch.
// R4 - Cycle unit is the oscillator, 1.024 MHz normal, 2.048 MHz turbo.
// R5 - A command takes effect at its latch point; single-shot counts from it.
// R6 - Two-bit reference select; internal reference after reset.
// R7 - Host waits up to 25 us for internal reference settling.
// R8 - Three-bit excitation current code; 000 disables both sources.
// R9 - Each source routed by its own three-bit field; same pin allowed.
// R10 - Host programs current first, then routing; allows 200 us start-up.
// R11 - Sources stay on between single shots; sleep command powers them down.
// R12 - Bias on whenever current nonzero and not asleep; output drawn only when routed.
// R13 - Burn-out enable sources into positive and sinks from negative input.
// R14 - Host keeps burn-out off for precision work, on only for fault tests.
// R15 - Three-bit rate code selects seven ascending rates; turbo doubles them.
// R16 - Ready returns high when a new conversion begins or result is read.
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ACS_A_CTRL 8'h00
`define ACS_A_EXC 8'h04
`define ACS_A_CMD 8'h08
`define ACS_A_STAT 8'h0C

// ****************************************
// Field positions
// ****************************************
`define ACS_B_CONT 0
`define ACS_B_TURBO 1
`define ACS_B_RATE 2
`define ACS_B_REF 5
`define ACS_B_BURN 7
`define ACS_B_CUR 0
`define ACS_B_R1 3
`define ACS_B_R2 6
`define ACS_B_START 0
`define ACS_B_SLEEP 1
`define ACS_B_ACK 2

// ****************************************
// Reset values
// ****************************************
`define ACS_CTRL_RST 8'h00
`define ACS_EXC_RST 9'h000

// ****************************************
// Timing, in oscillator cycles unless noted
// ****************************************
`define ACS_CLK_KHZ 40000
`define ACS_OSC_KHZ 1024
`define ACS_DLY_NORM_HALF 18'd57
`define ACS_DLY_TURBO 17'd105
`define ACS_CONT_0 17'd51192
`define ACS_CONT_1 17'd22780
`define ACS_CONT_2 17'd11532
`define ACS_CONT_3 17'd5916
`define ACS_CONT_4 17'd3116
`define ACS_CONT_5 17'd1724
`define ACS_CONT_6 17'd1036
`define ACS_SN_0 17'd51213
`define ACS_SN_1 17'd22805
`define ACS_SN_2 17'd11557
`define ACS_SN_3 17'd5941
`define ACS_SN_4 17'd3141
`define ACS_SN_5 17'd1749
`define ACS_SN_6 17'd1061
`define ACS_ST_0 17'd51217
`define ACS_ST_1 17'd22809
`define ACS_ST_2 17'd11561
`define ACS_ST_3 17'd5945
`define ACS_ST_4 17'd3145
`define ACS_ST_5 17'd1753
`define ACS_ST_6 17'd1065

`endif

// [core/acs_pkg.sv]
// Types shared by the converter sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package acs_pkg;
  typedef enum logic [1:0] {ACS_IDLE, ACS_DELAY, ACS_CONV} acs_state_e;
  typedef logic [17:0] acs_cnt_t;
  typedef logic [2:0] acs_code_t;
endpackage

// [core/acs_osc_div.sv]
// Fractional divider making the oscillator half-cycle enable.
// Assumes one system clock; clr restarts the phase at a start command latch.
`timescale 1ns/100ps
`include "acs_regs.svh"
module acs_osc_div #(
  parameter int CLK_KHZ = `ACS_CLK_KHZ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic turbo,
  output logic tick_q
);
  import acs_pkg::*;

  // Steps are twice the oscillator rate, so each tick is half a cycle.
  // That resolution is what lets the 28.5 cycle start delay be exact.
  localparam logic [17:0] STEP = 18'(2 * `ACS_OSC_KHZ);
  localparam logic [17:0] MODV = 18'(CLK_KHZ);
  logic [17:0] acc_q;
  logic [17:0] acc_d;
  logic tick_d;
  logic [17:0] sum;

  always_comb
  begin
    sum = acc_q + (turbo ? {STEP[16:0], 1'b0} : STEP); // [R4]
    tick_d = 1'b0;
    acc_d = sum;
    if (sum >= MODV)
    begin
      acc_d = sum - MODV;
      tick_d = 1'b1;
    end
    if (clr)
    begin
      acc_d = 18'h00000;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q <= 18'h00000;
      tick_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      tick_q <= tick_d;
    end
  end
endmodule

// [core/acs_top.sv]
// Conversion sequencer with reference and excitation control.
// Assumes a 40 MHz clock and a register master obeying the strobe port.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`include "acs_regs.svh"
module acs_top #(
  parameter int CLK_KHZ = `ACS_CLK_KHZ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic result_ready_n,
  output logic conv_active,
  output logic [1:0] ref_sel,
  output acs_pkg::acs_code_t excite_current_sel,
  output acs_pkg::acs_code_t excite1_route,
  output acs_pkg::acs_code_t excite2_route,
  output logic excite_bias_en,
  output logic excite1_on,
  output logic excite2_on,
  output logic burnout_src_en,
  output logic burnout_sink_en
);
  import acs_pkg::*;

  // ****************************************
  // Register port decode
  // ****************************************
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [8:0] exc_q;
  logic [8:0] exc_d;
  logic asleep_q;
  logic asleep_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic cmd_wr;
  logic cmd_start;
  logic cmd_sleep;
  logic cmd_ack;
  logic cont;
  logic turbo;
  acs_code_t rate;

  assign cmd_wr = reg_wr && reg_addr == `ACS_A_CMD;
  // A command is latched in the cycle its write strobe is seen.
  assign cmd_start = cmd_wr && reg_wdata[`ACS_B_START]; // [R5]
  assign cmd_sleep = cmd_wr && reg_wdata[`ACS_B_SLEEP];
  assign cmd_ack = cmd_wr && reg_wdata[`ACS_B_ACK];
  assign cont = ctrl_q[`ACS_B_CONT];
  assign turbo = ctrl_q[`ACS_B_TURBO];
  assign rate = ctrl_q[`ACS_B_RATE +: 3]; // [R15]

  // ****************************************
  // Sequencer state
  // ****************************************
  acs_state_e state_q;
  acs_state_e state_d;
  acs_cnt_t cnt_q;
  acs_cnt_t cnt_d;
  logic rdy_n_q;
  logic rdy_n_d;
  logic tick;

  acs_osc_div #(
    .CLK_KHZ(CLK_KHZ)
  ) u_div (
    .clk(clk),
    .rst_n(rst_n),
    .clr(cmd_start),
    .turbo(turbo),
    .tick_q(tick)
  );

  // Lengths are in half oscillator cycles, hence the appended zero.
  // Code 7 has no rate of its own and falls back to the fastest.
  function automatic acs_cnt_t cont_len(input acs_code_t r);
    logic [16:0] v;
    v = `ACS_CONT_6;
    case (r)
      3'h0: v = `ACS_CONT_0;
      3'h1: v = `ACS_CONT_1;
      3'h2: v = `ACS_CONT_2;
      3'h3: v = `ACS_CONT_3;
      3'h4: v = `ACS_CONT_4;
      3'h5: v = `ACS_CONT_5;
      default: v = `ACS_CONT_6;
    endcase
    return {v, 1'b0};
  endfunction

  function automatic acs_cnt_t single_len(input acs_code_t r,
                                          input logic t);
    logic [16:0] v;
    v = `ACS_SN_6;
    case (r)
      3'h0: v = t ? `ACS_ST_0 : `ACS_SN_0;
      3'h1: v = t ? `ACS_ST_1 : `ACS_SN_1;
      3'h2: v = t ? `ACS_ST_2 : `ACS_SN_2;
      3'h3: v = t ? `ACS_ST_3 : `ACS_SN_3;
      3'h4: v = t ? `ACS_ST_4 : `ACS_SN_4;
      3'h5: v = t ? `ACS_ST_5 : `ACS_SN_5;
      default: v = t ? `ACS_ST_6 : `ACS_SN_6;
    endcase
    return {v, 1'b0};
  endfunction

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    rdy_n_d = rdy_n_q;
    if (cmd_ack)
    begin
      rdy_n_d = 1'b1; // [R16]
    end
    if (cmd_sleep)
    begin
      state_d = ACS_IDLE;
    end
    else if (cmd_start)
    begin
      rdy_n_d = 1'b1; // [R16]
      if (cont)
      begin
        state_d = ACS_DELAY;
        cnt_d = turbo ? {`ACS_DLY_TURBO, 1'b0} : `ACS_DLY_NORM_HALF; // [R1]
      end
      else
      begin
        state_d = ACS_CONV;
        cnt_d = single_len(rate, turbo); // [R3]
      end
    end
    else if (tick && state_q != ACS_IDLE)
    begin
      cnt_d = cnt_q - 18'h00001;
      case (state_q)
        ACS_DELAY:
        begin
          if (cnt_q == 18'h00001)
          begin
            state_d = ACS_CONV;
            cnt_d = cont_len(rate); // [R2]
          end
        end
        ACS_CONV:
        begin
          // Rising half a cycle early keeps a falling edge every period.
          if (cont && cnt_q == 18'h00002)
          begin
            rdy_n_d = 1'b1; // [R16]
          end
          if (cnt_q == 18'h00001)
          begin
            rdy_n_d = 1'b0; // [R2] [R3]
            if (cont)
            begin
              cnt_d = cont_len(rate); // [R2]
            end
            else
            begin
              state_d = ACS_IDLE;
            end
          end
        end
        default: state_d = ACS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ACS_IDLE;
      cnt_q <= 18'h00000;
      rdy_n_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rdy_n_q <= rdy_n_d;
    end
  end

  assign result_ready_n = rdy_n_q;

  // ****************************************
  // Configuration registers and read port
  // ****************************************
  always_comb
  begin
    ctrl_d = ctrl_q;
    exc_d = exc_q;
    asleep_d = asleep_q;
    rdata_d = 32'h00000000;
    if (reg_wr && reg_addr == `ACS_A_CTRL)
    begin
      ctrl_d = reg_wdata[7:0]; // [R6] [R13] [R15]
    end
    if (reg_wr && reg_addr == `ACS_A_EXC)
    begin
      exc_d = reg_wdata[8:0]; // [R8] [R9]
    end
    if (cmd_start)
    begin
      asleep_d = 1'b0;
    end
    if (cmd_sleep)
    begin
      asleep_d = 1'b1; // [R11]
    end
    if (reg_rd)
    begin
      case (reg_addr)
        `ACS_A_CTRL: rdata_d = {24'h000000, ctrl_q};
        `ACS_A_EXC: rdata_d = {23'h000000, exc_q};
        `ACS_A_STAT: rdata_d = {28'h0000000, asleep_q,
                                state_q == ACS_DELAY,
                                state_q != ACS_IDLE, rdy_n_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= `ACS_CTRL_RST; // [R6]
      exc_q <= `ACS_EXC_RST;
      asleep_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      exc_q <= exc_d;
      asleep_q <= asleep_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign ref_sel = ctrl_q[`ACS_B_REF +: 2]; // [R6]
  assign excite_current_sel = exc_q[`ACS_B_CUR +: 3]; // [R8]
  assign excite1_route = exc_q[`ACS_B_R1 +: 3]; // [R9]
  assign excite2_route = exc_q[`ACS_B_R2 +: 3]; // [R9]

  // ****************************************
  // Analog enables
  // ****************************************
  // Enables follow the next register values so that they change at the
  // same edge as the fields they reflect. Sleep overrides the excitation enables, not burn-out.
  logic [5:0] en_q;
  logic [5:0] en_d;
  logic bias;

  always_comb
  begin
    bias = exc_d[`ACS_B_CUR +: 3] != 3'h0 && !asleep_d; // [R8] [R11] [R12]
    en_d[0] = bias;
    en_d[1] = bias && exc_d[`ACS_B_R1 +: 3] != 3'h0; // [R9] [R12]
    en_d[2] = bias && exc_d[`ACS_B_R2 +: 3] != 3'h0; // [R9] [R12]
    en_d[3] = ctrl_d[`ACS_B_BURN]; // [R13]
    en_d[4] = ctrl_d[`ACS_B_BURN]; // [R13]
    en_d[5] = state_d != ACS_IDLE;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_q <= 6'h00;
    end
    else
    begin
      en_q <= en_d;
    end
  end

  assign excite_bias_en = en_q[0];
  assign excite1_on = en_q[1];
  assign excite2_on = en_q[2];
  assign burnout_src_en = en_q[3];
  assign burnout_sink_en = en_q[4];
  assign conv_active = en_q[5];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  start_delay_a: assert property ( // [R1]
    cmd_start && !cmd_sleep && cont |=> state_q == ACS_DELAY &&
      cnt_q == (turbo ? 18'd210 : 18'd57))
    else $error("start delay not loaded");

  single_len_a: assert property ( // [R3]
    cmd_start && !cmd_sleep && !cont && rate[2:1] == 2'b11
      |=> cnt_q == (turbo ? 18'd2130 : 18'd2122))
    else $error("single-shot length wrong");

  ready_fall_a: assert property ( // [R2]
    $fell(rdy_n_q) |-> $past(tick) && $past(cnt_q) == 18'h00001 &&
      $past(state_q) == ACS_CONV)
    else $error("ready fell without completion");

  rate_reload_a: assert property ( // [R15]
    state_q == ACS_DELAY && tick && cnt_q == 18'h00001 && rate == 3'h6
      && !cmd_start && !cmd_sleep |=> cnt_q == 18'd2072)
    else $error("fast rate reload wrong");

  // A completion in the same cycle as the ack wins, so it is left out.
  ack_high_a: assert property ( // [R16]
    cmd_ack && !(tick && state_q == ACS_CONV && cnt_q == 18'h00001)
      |=> rdy_n_q)
    else $error("read ack left ready low");

  sleep_off_a: assert property ( // [R11]
    cmd_sleep |=> !excite_bias_en && !excite1_on && !excite2_on
      && state_q == ACS_IDLE)
    else $error("sleep left sources on");

  bias_on_a: assert property ( // [R12]
    reg_wr && reg_addr == `ACS_A_EXC && reg_wdata[2:0] != 3'h0 &&
      !asleep_q && !cmd_wr |=> excite_bias_en &&
      excite1_on == (excite1_route != 3'h0))
    else $error("bias or routing enable wrong");

  burnout_pair_a: assert property ( // [R13]
    reg_wr && reg_addr == `ACS_A_CTRL |=>
      burnout_src_en == $past(reg_wdata[7]) &&
      burnout_sink_en == burnout_src_en)
    else $error("burn-out enables disagree");

  ref_sel_a: assert property ( // [R6]
    reg_wr && reg_addr == `ACS_A_CTRL |=> ref_sel == $past(reg_wdata[6:5]))
    else $error("reference select not applied");
endmodule

// [dv/acs_host_model.sv]
// Host controller model driving the sequencer's register port.
// Assumes the strobe port of acs_top and a free-running clk.
`timescale 1ns/100ps
module acs_host_model #(
  parameter int EXC_SETTLE_CYC = 8000,
  parameter int REF_SETTLE_CYC = 1000
) (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  // ****************************************
  // Bus cycles
  // ****************************************
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Results taken before the reference settles would be off scale.
  task automatic set_ref(input logic [1:0] r);
    wr(8'h00, {24'h0, 1'b0, r, 5'h00});
    if (r == 2'b00)
      repeat (REF_SETTLE_CYC) @(posedge clk);
  endtask

  // Current first, then routing once the sources have started up.
  task automatic set_excite(input logic [2:0] c, input logic [2:0] r1,
                            input logic [2:0] r2);
    wr(8'h04, {29'h0, c});
    repeat (EXC_SETTLE_CYC) @(posedge clk);
    wr(8'h04, {23'h0, r2, r1, c});
  endtask
endmodule

// [dv/tb_adc_conversion_sequencer.sv]
// Self-checking bench for the converter sequencer.
// Assumes acs_top at a reduced CLK_KHZ so one half-tick is 2 or 1 clocks.
`timescale 1ns/100ps
`include "acs_regs.svh"
module tb_adc_conversion_sequencer;
  import acs_pkg::*;
  localparam int KHZ = 4096;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, result_ready_n, conv_active;
  logic [1:0] ref_sel;
  acs_code_t cur, r1, r2;
  logic bias, on1, on2, bsrc, bsnk;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int n, m, e;

`define CHK(a, b, s) begin checks_done++; if ((a) !== (b)) begin \
  failures++; $display("CHECK FAILED t=%0t %s", $time, s); end end

  always #12.5 clk = ~clk;

  acs_host_model host (.clk(clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  acs_top #(.CLK_KHZ(KHZ)) DUT (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .result_ready_n(result_ready_n), .conv_active(conv_active),
    .ref_sel(ref_sel), .excite_current_sel(cur), .excite1_route(r1),
    .excite2_route(r2), .excite_bias_en(bias), .excite1_on(on1),
    .excite2_on(on2), .burnout_src_en(bsrc), .burnout_sink_en(bsnk));

  // ****************************************
  // Helpers and closing
  // ****************************************
  task automatic print_verdict();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      failures++;
      print_verdict();
    end
  end

  // Counts clocks until the ready line shows level v.
  // The first step lets the updates of the current edge settle first.
  task automatic wait_lvl(input logic v, output int k);
    k = 0;
    #1;
    while (result_ready_n !== v && k < 20000)
    begin
      @(posedge clk);
      #1 k++;
    end
  endtask

  // The strobe-to-edge phase of the oscillator allows a few clocks slack.
  task automatic near(input int k, input int x, input string s);
    `CHK(k >= x - 3 && k <= x + 3, 1'b1, s)
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK(result_ready_n, 1'b1, "ready after reset")
    `CHK(ref_sel, 2'b00, "reference after reset")
    `CHK(bias, 1'b0, "bias after reset")
    host.rd(`ACS_A_CTRL, d);
    `CHK(d, 32'h0, "control after reset")
    host.wr(`ACS_A_STAT, 32'hFF);
    host.rd(`ACS_A_CTRL, d);
    `CHK(d, 32'h0, "status write ignored")
    host.rd(8'h10, d);
    `CHK(d, 32'h0, "unmapped read")
    for (int i = 3; i >= 0; i--)
    begin
      host.set_ref(i[1:0]);
      #1 `CHK(ref_sel, i[1:0], "reference select")
    end
    $display("test reference done");
    for (int c = 0; c < 8; c++)
    begin
      host.wr(`ACS_A_EXC, c);
      #1 `CHK(bias, c != 0, "bias follows current")
      `CHK(on1 | on2, 1'b0, "no output unrouted")
    end
    host.set_excite(3'h5, 3'h3, 3'h3);
    #1 `CHK({on1, on2, r1, r2}, 8'hDB, "both sources on one pin")
    `CHK(cur, 3'h5, "current select")
    host.rd(`ACS_A_EXC, d);
    `CHK(d, 32'h0DD, "excitation read back")
    host.wr(`ACS_A_CTRL, 32'h80);
    #1 `CHK({bsrc, bsnk}, 2'b11, "burn-out on")
    host.wr(`ACS_A_CTRL, 32'h00);
    #1 `CHK({bsrc, bsnk}, 2'b00, "burn-out off")
    $display("test excitation done");
    for (int t = 0; t < 3; t++)
    begin
      m = (t == 1) ? 2 : 1;
      host.wr(`ACS_A_CTRL, t == 0 ? 32'h18 : t == 1 ? 32'h1E : 32'h14);
      host.wr(`ACS_A_CMD, 32'h1);
      host.rd(`ACS_A_STAT, d);
      `CHK(d, 32'h3, "busy after start")
      wait_lvl(1'b0, n);
      e = int'(t == 0 ? `ACS_SN_6 : t == 1 ? `ACS_ST_6 : `ACS_SN_5);
      e = 2 * e * KHZ / (2048 * m);
      near(n, e, "single-shot ready time");
      `CHK(conv_active, 1'b0, "idle after single shot")
      `CHK(bias, 1'b1, "sources kept between shots")
      host.wr(`ACS_A_CMD, 32'h4);
      #1 `CHK(result_ready_n, 1'b1, "ready cleared by read")
    end
    host.wr(`ACS_A_CMD, 32'h2);
    #1 `CHK({bias, on1, on2}, 3'b000, "sleep powers sources down")
    $display("test single-shot done");
    for (int t = 0; t < 2; t++)
    begin
      host.wr(`ACS_A_CTRL, t ? 32'h1B : 32'h19);
      host.wr(`ACS_A_CMD, 32'h1);
      host.rd(`ACS_A_STAT, d);
      `CHK(d, 32'h7, "delay phase after start")
      wait_lvl(1'b0, n);
      e = ((t ? 210 : 57) + 2 * `ACS_CONT_6) * KHZ / (2048 * (t + 1));
      near(n, e, "first conversion delay");
      wait_lvl(1'b1, m);
      wait_lvl(1'b0, n);
      e = 2 * `ACS_CONT_6 * KHZ / (2048 * (t + 1));
      near(m + n, e, "continuous spacing");
      host.wr(`ACS_A_CMD, 32'h2);
      #1 `CHK(conv_active, 1'b0, "sleep stops conversions")
      host.rd(`ACS_A_STAT, d);
      `CHK(d, 32'h8, "status after sleep")
    end
    $display("test continuous done");
    print_verdict();
  end
endmodule
